// ==== rtl/ppl_pkg.sv ====
// Constants, object indices and carrier types of the probe position latch.
// Assumes one system clock domain; every user of it names items as ppl_pkg::name.
package ppl_pkg;

  // Object dictionary indices and sub-indices
  localparam logic [15:0] IDX_CTRL          = 16'h60B8;
  localparam logic [15:0] IDX_STATE         = 16'h60B9;
  localparam logic [15:0] IDX_ONE_RISE_POS  = 16'h60BA;
  localparam logic [15:0] IDX_ONE_FALL_POS  = 16'h60BB;
  localparam logic [15:0] IDX_TWO_RISE_POS  = 16'h60BC;
  localparam logic [15:0] IDX_TWO_FALL_POS  = 16'h60BD;
  localparam logic [15:0] IDX_ONE_RISE_CNT  = 16'h60D5;
  localparam logic [15:0] IDX_ONE_FALL_CNT  = 16'h60D6;
  localparam logic [15:0] IDX_TWO_RISE_CNT  = 16'h60D7;
  localparam logic [15:0] IDX_TWO_FALL_CNT  = 16'h60D8;
  localparam logic [15:0] IDX_IN_FUNC       = 16'h2152;
  localparam logic [7:0]  SUB_ZERO          = 8'h00;
  localparam logic [7:0]  SUB_IN_ONE        = 8'h01;
  localparam logic [7:0]  SUB_IN_TWO        = 8'h02;

  // Values after reset
  localparam logic [15:0] CTRL_RST          = 16'h0000;
  localparam logic [15:0] FUNC_ONE_RST      = 16'h0001;
  localparam logic [15:0] FUNC_TWO_RST      = 16'h0002;
  localparam logic [31:0] POS_RST           = 32'h0000_0000;
  localparam logic [15:0] COUNT_RST         = 16'h0000;

  // Input function codes, one-hot
  localparam logic [15:0] FUNC_HOME         = 16'h0001;
  localparam logic [15:0] FUNC_NEG_LIMIT    = 16'h0002;
  localparam logic [15:0] FUNC_POS_LIMIT    = 16'h0004;
  localparam logic [15:0] FUNC_QUICK_STOP   = 16'h0008;
  localparam logic [15:0] FUNC_USER         = 16'h0010;
  localparam logic [15:0] FUNC_PROBE_ONE    = 16'h0020;
  localparam logic [15:0] FUNC_PROBE_TWO    = 16'h0040;

  // Control word layout; channel two sits one stride above channel one
  localparam int          CH_STRIDE         = 8;
  localparam int          CTRL_EN_BIT       = 0;
  localparam int          CTRL_MODE_BIT     = 1;
  localparam int          CTRL_RISE_BIT     = 4;
  localparam int          CTRL_FALL_BIT     = 5;
  localparam logic [15:0] CTRL_WRITE_MASK   = 16'h3333;

  // State word layout
  localparam int          ST_ACTIVE_BIT     = 0;
  localparam int          ST_RISE_DONE_BIT  = 1;
  localparam int          ST_FALL_DONE_BIT  = 2;

  // Trigger counter ceiling
  localparam logic [15:0] COUNT_MAX         = 16'h8000;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } ppl_od_req_t;

  typedef struct packed {
    logic        ack;
    logic        error;
    logic [31:0] rdata;
  } ppl_od_rsp_t;

  typedef struct packed {
    logic continuous;
    logic rise_en;
    logic fall_en;
  } ppl_arm_cfg_t;

  typedef enum logic [1:0] {
    CH_STOPPED,
    CH_ARMED,
    CH_SPENT
  } ppl_ch_state_t;

endpackage

// ==== rtl/ppl_probe_latch.sv ====
// Two-channel probe position latch: control and state words, position latches, counters.
// Assumes position_in is on clk_sys; probe pins are asynchronous and pass a synchroniser.
`timescale 1ns/1ps
module ppl_probe_latch #(
  parameter int NUM_CH    = 2,
  parameter int POS_WIDTH = 32,
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Digital input pins
  input  wire logic                        first_digital_input,
  input  wire logic                        second_digital_input,
  // Axis position
  input  wire logic signed [POS_WIDTH-1:0] position_in,
  // Object access port
  input  wire ppl_pkg::ppl_od_req_t        od_req,
  output ppl_pkg::ppl_od_rsp_t             od_rsp_q,
  // Probe state word copy
  output logic             [15:0]          probe_state_q
);

  // Input function code that routes an input into a channel
  function automatic logic feeds_channel(input logic [15:0] func, input int ch);
    feeds_channel = (ch == 0) ? (func == ppl_pkg::FUNC_PROBE_ONE)
                              : (func == ppl_pkg::FUNC_PROBE_TWO);
  endfunction

  // Object match on index and sub-index
  function automatic logic is_obj(input ppl_pkg::ppl_od_req_t req,
                                  input logic [15:0] idx,
                                  input logic [7:0]  sub);
    is_obj = (req.index == idx) && (req.subindex == sub);
  endfunction

  // Registers
  logic [15:0]                 ctrl_q;
  logic [15:0]                 func_one_q;
  logic [15:0]                 func_two_q;
  logic [NUM_CH-1:0]           en_prev_q;
  logic [NUM_CH-1:0]           rise_done_q;
  logic [NUM_CH-1:0]           fall_done_q;
  logic signed [POS_WIDTH-1:0] pos_rise_q [NUM_CH];
  logic signed [POS_WIDTH-1:0] pos_fall_q [NUM_CH];
  logic [CNT_WIDTH-1:0]        cnt_rise [NUM_CH];
  logic [CNT_WIDTH-1:0]        cnt_fall [NUM_CH];
  ppl_pkg::ppl_arm_cfg_t       cfg_q [NUM_CH];
  ppl_pkg::ppl_ch_state_t      state_q [NUM_CH];

  // Combinational
  logic [1:0]                  pin_rise;
  logic [1:0]                  pin_fall;
  logic [NUM_CH-1:0]           ch_en;
  logic [NUM_CH-1:0]           ch_arm;
  logic [NUM_CH-1:0]           ch_rise;
  logic [NUM_CH-1:0]           ch_fall;
  logic [NUM_CH-1:0]           qual_rise;
  logic [NUM_CH-1:0]           qual_fall;
  logic [15:0]                 state_word;
  logic [31:0]                 rd_data;
  logic                        rd_known;
  logic                        wr_ok;

  // Pin synchroniser and edge detect
  ppl_sync_edge #(
    .WIDTH   (2)
  ) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  ({second_digital_input, first_digital_input}),
    .level_q (),
    .rise_q  (pin_rise),
    .fall_q  (pin_fall)
  );

  genvar c;
  generate
    for (c = 0; c < NUM_CH; c++) begin : g_ch
      localparam int BASE = c * ppl_pkg::CH_STRIDE;

      // Both inputs may feed one channel; their edges then overlay
      assign ch_rise[c] = (pin_rise[0] & feeds_channel(func_one_q, c))
                        | (pin_rise[1] & feeds_channel(func_two_q, c));
      assign ch_fall[c] = (pin_fall[0] & feeds_channel(func_one_q, c))
                        | (pin_fall[1] & feeds_channel(func_two_q, c));

      assign ch_en[c]  = ctrl_q[BASE + ppl_pkg::CTRL_EN_BIT];
      assign ch_arm[c] = ch_en[c] & ~en_prev_q[c];

      assign qual_rise[c] = (state_q[c] == ppl_pkg::CH_ARMED) && ch_en[c]
                          && cfg_q[c].rise_en && ch_rise[c];
      assign qual_fall[c] = (state_q[c] == ppl_pkg::CH_ARMED) && ch_en[c]
                          && cfg_q[c].fall_en && ch_fall[c];

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          en_prev_q[c] <= 1'b0;
        end else begin
          en_prev_q[c] <= ch_en[c];
        end
      end

      // Settings are frozen at the enable edge, later control writes do not reach them
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          cfg_q[c] <= '0;
        end else if (ch_arm[c]) begin
          cfg_q[c].continuous <= ctrl_q[BASE + ppl_pkg::CTRL_MODE_BIT];
          cfg_q[c].rise_en    <= ctrl_q[BASE + ppl_pkg::CTRL_RISE_BIT];
          cfg_q[c].fall_en    <= ctrl_q[BASE + ppl_pkg::CTRL_FALL_BIT];
        end
      end

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          state_q[c] <= ppl_pkg::CH_STOPPED;
        end else begin
          case (state_q[c])
            ppl_pkg::CH_STOPPED: begin
              if (ch_arm[c]) begin
                state_q[c] <= ppl_pkg::CH_ARMED;
              end
            end
            ppl_pkg::CH_ARMED: begin
              if (!ch_en[c]) begin
                state_q[c] <= ppl_pkg::CH_STOPPED;
              end else if ((qual_rise[c] || qual_fall[c]) && !cfg_q[c].continuous) begin
                state_q[c] <= ppl_pkg::CH_SPENT;
              end
            end
            ppl_pkg::CH_SPENT: begin
              if (!ch_en[c]) begin
                state_q[c] <= ppl_pkg::CH_STOPPED;
              end
            end
            default: begin
              state_q[c] <= ppl_pkg::CH_STOPPED;
            end
          endcase
        end
      end

      // Arming only happens from stopped, so it never meets a capture in one cycle
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          rise_done_q[c] <= 1'b0;
        end else if (qual_rise[c]) begin
          rise_done_q[c] <= 1'b1;
        end else if (ch_arm[c]) begin
          rise_done_q[c] <= 1'b0;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          fall_done_q[c] <= 1'b0;
        end else if (qual_fall[c]) begin
          fall_done_q[c] <= 1'b1;
        end else if (ch_arm[c]) begin
          fall_done_q[c] <= 1'b0;
        end
      end

      // Position taken in the cycle the synchronised edge shows
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          pos_rise_q[c] <= ppl_pkg::POS_RST;
        end else if (qual_rise[c]) begin
          pos_rise_q[c] <= position_in;
        end
      end

      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          pos_fall_q[c] <= ppl_pkg::POS_RST;
        end else if (qual_fall[c]) begin
          pos_fall_q[c] <= position_in;
        end
      end

      ppl_trig_counter #(
        .WIDTH   (CNT_WIDTH),
        .MAX     (ppl_pkg::COUNT_MAX)
      ) u_cnt_rise (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clear   (ch_arm[c]),
        .step    (qual_rise[c] & cfg_q[c].continuous),
        .count_q (cnt_rise[c])
      );

      ppl_trig_counter #(
        .WIDTH   (CNT_WIDTH),
        .MAX     (ppl_pkg::COUNT_MAX)
      ) u_cnt_fall (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .clear   (ch_arm[c]),
        .step    (qual_fall[c] & cfg_q[c].continuous),
        .count_q (cnt_fall[c])
      );
    end
  endgenerate

  // State word; reserved bits stay zero
  always_comb begin
    state_word = 16'h0000;
    for (int i = 0; i < NUM_CH; i++) begin
      state_word[i*ppl_pkg::CH_STRIDE + ppl_pkg::ST_ACTIVE_BIT] =
        (state_q[i] == ppl_pkg::CH_ARMED);
      state_word[i*ppl_pkg::CH_STRIDE + ppl_pkg::ST_RISE_DONE_BIT] = rise_done_q[i];
      state_word[i*ppl_pkg::CH_STRIDE + ppl_pkg::ST_FALL_DONE_BIT] = fall_done_q[i];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      probe_state_q <= 16'h0000;
    end else begin
      probe_state_q <= state_word;
    end
  end

  // Read decode
  always_comb begin
    rd_data  = 32'h0000_0000;
    rd_known = 1'b1;
    wr_ok    = 1'b0;
    if (is_obj(od_req, ppl_pkg::IDX_CTRL, ppl_pkg::SUB_ZERO)) begin
      rd_data = {16'h0000, ctrl_q};
      wr_ok   = 1'b1;
    end else if (is_obj(od_req, ppl_pkg::IDX_STATE, ppl_pkg::SUB_ZERO)) begin
      rd_data = {16'h0000, state_word};
    end else if (is_obj(od_req, ppl_pkg::IDX_ONE_RISE_POS, ppl_pkg::SUB_ZERO)) begin
      rd_data = pos_rise_q[0];
    end else if (is_obj(od_req, ppl_pkg::IDX_ONE_FALL_POS, ppl_pkg::SUB_ZERO)) begin
      rd_data = pos_fall_q[0];
    end else if (is_obj(od_req, ppl_pkg::IDX_TWO_RISE_POS, ppl_pkg::SUB_ZERO)) begin
      rd_data = pos_rise_q[1];
    end else if (is_obj(od_req, ppl_pkg::IDX_TWO_FALL_POS, ppl_pkg::SUB_ZERO)) begin
      rd_data = pos_fall_q[1];
    end else if (is_obj(od_req, ppl_pkg::IDX_ONE_RISE_CNT, ppl_pkg::SUB_ZERO)) begin
      rd_data = {16'h0000, cnt_rise[0]};
    end else if (is_obj(od_req, ppl_pkg::IDX_ONE_FALL_CNT, ppl_pkg::SUB_ZERO)) begin
      rd_data = {16'h0000, cnt_fall[0]};
    end else if (is_obj(od_req, ppl_pkg::IDX_TWO_RISE_CNT, ppl_pkg::SUB_ZERO)) begin
      rd_data = {16'h0000, cnt_rise[1]};
    end else if (is_obj(od_req, ppl_pkg::IDX_TWO_FALL_CNT, ppl_pkg::SUB_ZERO)) begin
      rd_data = {16'h0000, cnt_fall[1]};
    end else if (is_obj(od_req, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_ONE)) begin
      rd_data = {16'h0000, func_one_q};
      wr_ok   = 1'b1;
    end else if (is_obj(od_req, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_TWO)) begin
      rd_data = {16'h0000, func_two_q};
      wr_ok   = 1'b1;
    end else begin
      rd_known = 1'b0;
    end
  end

  // Control word keeps only its defined bits
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= ppl_pkg::CTRL_RST;
    end else if (od_req.valid && od_req.write
                 && is_obj(od_req, ppl_pkg::IDX_CTRL, ppl_pkg::SUB_ZERO)) begin
      ctrl_q <= od_req.wdata[15:0] & ppl_pkg::CTRL_WRITE_MASK;
    end
  end

  // Function codes are stored whole; only the two probe codes route a pin here
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      func_one_q <= ppl_pkg::FUNC_ONE_RST;
      func_two_q <= ppl_pkg::FUNC_TWO_RST;
    end else if (od_req.valid && od_req.write) begin
      if (is_obj(od_req, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_ONE)) begin
        func_one_q <= od_req.wdata[15:0];
      end
      if (is_obj(od_req, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_TWO)) begin
        func_two_q <= od_req.wdata[15:0];
      end
    end
  end

  // Answer one cycle after each request; unknown objects and writes to read-only fail
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      od_rsp_q <= '0;
    end else begin
      od_rsp_q.ack   <= od_req.valid;
      od_rsp_q.error <= od_req.valid && (!rd_known || (od_req.write && !wr_ok));
      od_rsp_q.rdata <= (od_req.valid && !od_req.write) ? rd_data : 32'h0000_0000;
    end
  end

endmodule

// ==== rtl/ppl_sync_edge.sv ====
// Two-stage synchroniser with registered edge detect for asynchronous pins.
// Assumes pins are asynchronous to clk_sys and held for at least two clock periods.
`timescale 1ns/1ps
module ppl_sync_edge #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Raw pins
  input  wire logic [WIDTH-1:0] pin_in,
  // Synchronised level and one-cycle edge pulses
  output logic      [WIDTH-1:0] level_q,
  output logic      [WIDTH-1:0] rise_q,
  output logic      [WIDTH-1:0] fall_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] prev_q;

  // First stage is read only by the second stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q  <= '0;
      level_q <= '0;
    end else begin
      meta_q  <= pin_in;
      level_q <= meta_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      prev_q <= '0;
      rise_q <= '0;
      fall_q <= '0;
    end else begin
      prev_q <= level_q;
      rise_q <= level_q & ~prev_q;
      fall_q <= ~level_q & prev_q;
    end
  end

endmodule

// ==== rtl/ppl_trig_counter.sv ====
// Saturating trigger counter for one probe channel and edge direction.
// Assumes clear and step come from logic on clk_sys.
`timescale 1ns/1ps
module ppl_trig_counter #(
  parameter int              WIDTH = 16,
  parameter logic [WIDTH-1:0] MAX  = ppl_pkg::COUNT_MAX
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Control
  input  wire logic             clear,
  input  wire logic             step,
  // Count
  output logic      [WIDTH-1:0] count_q
);

  // Holds at the ceiling rather than wrapping, so a flood of edges never reads as few
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_q <= '0;
    end else if (step && (count_q < MAX)) begin
      count_q <= count_q + 1'b1;
    end else if (clear) begin
      count_q <= '0;
    end
  end

endmodule

// ==== verification/ppl_master_model.sv ====
// Fieldbus master model: issues object reads and writes on the access port.
// Assumes one clk_sys domain; requests launch on the falling edge.
`timescale 1ns/1ps
module ppl_master_model (
  // Clock
  input  wire logic                 clk_sys,
  // Object access port
  output ppl_pkg::ppl_od_req_t      od_req,
  input  wire ppl_pkg::ppl_od_rsp_t od_rsp_q
);
  initial od_req = '0;

  // Released fields are inverted so a stale request can never look valid by accident
  task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(negedge clk_sys);
    od_req = '{1'b1, w, idx, sub, wd};
    @(negedge clk_sys);
    od_req = '{1'b0, ~w, ~idx, ~sub, ~wd};
    while (od_rsp_q.ack !== 1'b1 && n < 4) begin
      @(negedge clk_sys);
      n++;
    end
    rd = od_rsp_q.rdata;
    err = (od_rsp_q.ack === 1'b1) ? od_rsp_q.error : 1'bx;
  endtask
endmodule

// ==== verification/ppl_probe_latch_asserts.sv ====
// Checker for the probe position latch, bound to its top ports.
// Assumes one clock domain and that control writes take effect at the taking edge.
`timescale 1ns/1ps
module ppl_probe_latch_asserts #(
  parameter int NUM_CH    = 2,
  parameter int POS_WIDTH = 32,
  parameter int CNT_WIDTH = 16
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        sys_rst,
  // Observed ports
  input  wire logic                        first_digital_input,
  input  wire logic                        second_digital_input,
  input  wire logic signed [POS_WIDTH-1:0] position_in,
  input  wire ppl_pkg::ppl_od_req_t        od_req,
  input  wire ppl_pkg::ppl_od_rsp_t        od_rsp_q,
  input  wire logic             [15:0]     probe_state_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  logic [15:0] ctrl_q;
  logic [1:0]  pin_q;
  logic [3:0]  since_pin_q;
  logic        ro_hit;

  assign ro_hit = od_req.index inside {[ppl_pkg::IDX_STATE : ppl_pkg::IDX_TWO_FALL_POS],
                                       [ppl_pkg::IDX_ONE_RISE_CNT : ppl_pkg::IDX_TWO_FALL_CNT]};

  // Shadow of the last control write, used to know when a channel is armed
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= '0;
    end else if (od_req.valid && od_req.write && od_req.index == ppl_pkg::IDX_CTRL) begin
      ctrl_q <= od_req.wdata[15:0];
    end
  end

  // Cycles since the last pin change, saturating so it never wraps into the window
  always_ff @(posedge clk_sys) begin
    pin_q <= {second_digital_input, first_digital_input};
    if (sys_rst) begin
      since_pin_q <= 4'hF;
    end else if ({second_digital_input, first_digital_input} != pin_q) begin
      since_pin_q <= '0;
    end else if (since_pin_q != 4'hF) begin
      since_pin_q <= since_pin_q + 4'h1;
    end
  end

  sequence seq_ctrl_write;
    od_req.valid && od_req.write && od_req.index == ppl_pkg::IDX_CTRL
      && od_req.subindex == ppl_pkg::SUB_ZERO;
  endsequence

  sequence seq_ctrl_read;
    od_req.valid && !od_req.write && od_req.index == ppl_pkg::IDX_CTRL
      && od_req.subindex == ppl_pkg::SUB_ZERO;
  endsequence

  a_ack_next_cycle: assert property (od_req.valid |=> od_rsp_q.ack)
    else $error("no acknowledge one cycle after a request");
  a_ack_idle_quiet: assert property (!od_req.valid |=> !od_rsp_q.ack)
    else $error("acknowledge without a request");
  a_rsp_idle_zero: assert property (!od_rsp_q.ack |-> od_rsp_q.rdata == 32'h0000_0000 && !od_rsp_q.error)
    else $error("response fields not zero while idle");
  a_ro_write_refused: assert property (od_req.valid && od_req.write && ro_hit
      && od_req.subindex == ppl_pkg::SUB_ZERO |=> od_rsp_q.ack && od_rsp_q.error)
    else $error("write to read-only object not refused");
  a_ctrl_write_ok: assert property (seq_ctrl_write |=> od_rsp_q.ack && !od_rsp_q.error)
    else $error("control write refused");
  a_ctrl_rsvd_zero: assert property (seq_ctrl_read |=> od_rsp_q.rdata[31:16] == 16'h0000
      && (od_rsp_q.rdata[15:0] & ~ppl_pkg::CTRL_WRITE_MASK) == 16'h0000)
    else $error("reserved control bits read nonzero");
  a_state_rsvd_zero: assert property ((probe_state_q & 16'hF8F8) == 16'h0000)
    else $error("reserved state bits set");
  a_arm_sets_active: assert property ($rose(ctrl_q[0]) |-> ##[1:4] probe_state_q[0])
    else $error("probe one not active after enable");
  a_stop_clears_act: assert property ($fell(ctrl_q[8]) |-> ##[1:4] !probe_state_q[8])
    else $error("probe two still active after stop");
  a_done_after_pin: assert property ($rose(|{probe_state_q[10:9], probe_state_q[2:1]})
      |-> since_pin_q inside {[4'h2 : 4'h7]})
    else $error("capture flag not tied to a recent pin edge");
endmodule

bind ppl_probe_latch ppl_probe_latch_asserts #(
  .NUM_CH(NUM_CH), .POS_WIDTH(POS_WIDTH), .CNT_WIDTH(CNT_WIDTH)
) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .first_digital_input(first_digital_input),
  .second_digital_input(second_digital_input), .position_in(position_in),
  .od_req(od_req), .od_rsp_q(od_rsp_q), .probe_state_q(probe_state_q)
);

// ==== verification/testbench.sv ====
// Self-checking bench for the probe position latch with a fieldbus master model.
// Assumes the checker is bound separately; pins and position change on falling edges.
`timescale 1ns/1ps
module testbench;
  logic                 clk_sys;
  logic                 sys_rst;
  logic                 first_digital_input;
  logic                 second_digital_input;
  logic signed [31:0]   position_in;
  ppl_pkg::ppl_od_req_t od_req;
  ppl_pkg::ppl_od_rsp_t od_rsp_q;
  logic [15:0]          probe_state_q;
  logic [31:0]          rd;
  logic                 err;
  int                   n_mismatch;
  int                   checked;

  ppl_probe_latch DUT (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .first_digital_input(first_digital_input),
    .second_digital_input(second_digital_input), .position_in(position_in),
    .od_req(od_req), .od_rsp_q(od_rsp_q), .probe_state_q(probe_state_q)
  );
  ppl_master_model u_master (.clk_sys(clk_sys), .od_req(od_req), .od_rsp_q(od_rsp_q));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Every access is judged on both the error flag and the returned word
  task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic e, input logic [31:0] x);
    u_master.access(w, idx, sub, wd, rd, err);
    check({err, rd}, {e, x});
  endtask

  task automatic rdo(input logic [15:0] idx, input logic [31:0] x);
    acc(1'b0, idx, ppl_pkg::SUB_ZERO, 32'h0000_0000, 1'b0, x);
  endtask

  task automatic wro(input logic [15:0] idx, input logic [31:0] wd);
    acc(1'b1, idx, ppl_pkg::SUB_ZERO, wd, 1'b0, 32'h0000_0000);
    repeat (3) @(negedge clk_sys);
  endtask

  // Pin held eight cycles each way so both edges pass the synchroniser
  task automatic pulse(input logic two, input logic [31:0] p_rise, input logic [31:0] p_fall);
    @(negedge clk_sys);
    position_in = p_rise;
    if (two) second_digital_input = 1'b1;
    else first_digital_input = 1'b1;
    repeat (8) @(negedge clk_sys);
    position_in = p_fall;
    if (two) second_digital_input = 1'b0;
    else first_digital_input = 1'b0;
    repeat (8) @(negedge clk_sys);
  endtask

  task automatic t_access();
    rdo(ppl_pkg::IDX_CTRL, 32'h0000_0000);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rdo(ppl_pkg::IDX_ONE_RISE_POS + 16'(i), 32'h0000_0000);
    for (int i = 0; i < 4; i++) rdo(ppl_pkg::IDX_ONE_RISE_CNT + 16'(i), 32'h0000_0000);
    acc(1'b0, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_ONE, 32'h0, 1'b0, 32'h0000_0001);
    acc(1'b0, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_TWO, 32'h0, 1'b0, 32'h0000_0002);
    acc(1'b1, ppl_pkg::IDX_ONE_RISE_CNT, 8'h00, 32'h5, 1'b1, 32'h0000_0000);
    acc(1'b0, 16'h1234, 8'h00, 32'h0, 1'b1, 32'h0000_0000);
    wro(ppl_pkg::IDX_CTRL, 32'h0000_FFFF);
    rdo(ppl_pkg::IDX_CTRL, 32'h0000_3333);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0101);
    wro(ppl_pkg::IDX_CTRL, 32'h0000_0000);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0000);
  endtask

  task automatic t_single();
    wro(ppl_pkg::IDX_CTRL, 32'h0000_0011);
    pulse(1'b0, 32'h0000_0099, 32'h0000_0098);
    rdo(ppl_pkg::IDX_ONE_RISE_POS, 32'h0000_0000);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0001);
    acc(1'b1, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_ONE, 32'h20, 1'b0, 32'h0);
    pulse(1'b0, 32'h8000_0005, 32'h0000_0777);
    rdo(ppl_pkg::IDX_ONE_RISE_POS, 32'h8000_0005);
    rdo(ppl_pkg::IDX_ONE_FALL_POS, 32'h0000_0000);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0002);
    pulse(1'b0, 32'h0000_1234, 32'h0000_4321);
    rdo(ppl_pkg::IDX_ONE_RISE_POS, 32'h8000_0005);
    rdo(ppl_pkg::IDX_ONE_RISE_CNT, 32'h0000_0000);
    wro(ppl_pkg::IDX_CTRL, 32'h0000_0000);
    wro(ppl_pkg::IDX_CTRL, 32'h0000_0021);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0001);
    pulse(1'b0, 32'h0000_0011, 32'hFFFF_FFF0);
    rdo(ppl_pkg::IDX_ONE_FALL_POS, 32'hFFFF_FFF0);
    rdo(ppl_pkg::IDX_ONE_RISE_POS, 32'h8000_0005);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0004);
  endtask

  task automatic t_cont();
    acc(1'b1, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_TWO, 32'h40, 1'b0, 32'h0);
    wro(ppl_pkg::IDX_CTRL, 32'h0000_3300);
    for (int i = 0; i < 3; i++) pulse(1'b1, 32'h100 + i, 32'hFFFF_FF00 - i);
    rdo(ppl_pkg::IDX_TWO_RISE_POS, 32'h0000_0102);
    rdo(ppl_pkg::IDX_TWO_FALL_POS, 32'hFFFF_FEFE);
    rdo(ppl_pkg::IDX_TWO_RISE_CNT, 32'h0000_0003);
    rdo(ppl_pkg::IDX_TWO_FALL_CNT, 32'h0000_0003);
    rdo(ppl_pkg::IDX_ONE_FALL_CNT, 32'h0000_0000);
    rdo(ppl_pkg::IDX_STATE, 32'h0000_0704);
    wro(ppl_pkg::IDX_CTRL, 32'h0000_1300);
    pulse(1'b1, 32'h0000_0200, 32'h0000_0300);
    rdo(ppl_pkg::IDX_TWO_FALL_POS, 32'h0000_0300);
    rdo(ppl_pkg::IDX_TWO_FALL_CNT, 32'h0000_0004);
    acc(1'b1, ppl_pkg::IDX_IN_FUNC, ppl_pkg::SUB_IN_TWO, 32'h10, 1'b0, 32'h0);
    pulse(1'b1, 32'h0000_0400, 32'h0000_0500);
    rdo(ppl_pkg::IDX_TWO_RISE_POS, 32'h0000_0200);
    rdo(ppl_pkg::IDX_TWO_RISE_CNT, 32'h0000_0004);
  endtask

  initial begin
    n_mismatch = 0;
    checked = 0;
    sys_rst = 1'b1;
    first_digital_input = 1'b0;
    second_digital_input = 1'b0;
    position_in = '0;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_access();
    t_single();
    t_cont();
    end_of_test();
  end

  // The tests need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test();
  end
endmodule
